// [src/ltp_top.sv]
// Logic output pair with time proportioning, scaling and standby actions.
// Assumes all control inputs come from logic on CLK, so none is synchronised.
// Overview of operation
// - First channel valve_raise forces second channel to valve_lower, locked.
// - In valve mode the second channel takes the first channel's settings.
// - Standby action off drives electrical low, ignoring inversion.
// - Standby action on drives electrical high, ignoring inversion, except in valve mode where both outputs follow their sources.
// - Continue with a wired source keeps following the wire.
// - Continue with no source holds the last written state.
// - Continue with a comms source keeps applying comms writes.
// - Valve freeze stops both raise and lower outputs in standby.
// - Valve continue lets both outputs follow their sources in standby.
// - Only one of fixed period and minimum switch time runs.
// - Fixed period on time is duty times period, off for the rest.
// - Minimum time mode holds each state at least the minimum time.
// - Default scaling gives off at 0, on at full, half at half.
// - Upper output limit below full scale prevents fully on output.
// - Lower output limit above zero prevents fully off output.
// - Scaling applies only to time proportioning outputs.
// - Demand limits map exactly onto the output limits.
// - Calibration raise drives the valve open, overriding the loop.
// - Calibration lower drives the valve closed.
// - Automatic minimum switch time uses 20 ms.
// - Inversion applies except to time proportioning and valve raise.
module ltp_top #(
   parameter int TICK_CYC = ltp_pkg::TICK_CYC,
   parameter int PW       = ltp_pkg::PERIOD_W,
   parameter int MW       = ltp_pkg::MIN_W
) (
   input  wire logic           CLK,
   input  wire logic           RST,
   input  wire logic           STANDBY,
   input  ltp_pkg::ltp_func_e  FUNC_A,
   input  ltp_pkg::ltp_func_e  FUNC_B,
   input  wire logic           INVERT_A,
   input  wire logic           INVERT_B,
   input  ltp_pkg::ltp_sby_e   SBY_A,
   input  ltp_pkg::ltp_sby_e   SBY_B,
   input  ltp_pkg::ltp_src_e   SRC_A,
   input  ltp_pkg::ltp_src_e   SRC_B,
   input  ltp_pkg::ltp_cal_e   CAL_STATE,
   input  wire logic [PW-1:0]  FIXED_PERIOD,
   input  wire logic [MW-1:0]  MIN_SWITCH,
   input  wire logic [13:0]    DEMAND_LO,
   input  wire logic [13:0]    DEMAND_HI,
   input  wire logic [13:0]    OUTPUT_LO,
   input  wire logic [13:0]    OUTPUT_HI,
   input  wire logic [13:0]    DEMAND_WIRE,
   input  wire logic           LEVEL_B_WIRE,
   input  wire logic           COMMS_WE_A,
   input  wire logic [13:0]    COMMS_DEMAND_A,
   input  wire logic           COMMS_WE_B,
   input  wire logic           COMMS_LEVEL_B,
   output logic                OUT_A,
   output logic                OUT_B,
   output ltp_pkg::ltp_func_e  B_FUNC,
   output logic                ALGO_FIXED,
   output logic [13:0]         DUTY
);

   localparam int TW = $clog2(TICK_CYC + 1);

   ltp_scale_if sc ();

   logic [TW-1:0]      pre_reg;
   logic               tick;
   logic [13:0]        dem_reg;
   logic               lvl_b_reg;
   logic [PW-1:0]      ph_reg;
   logic [PW-1:0]      on_ticks_reg;
   logic signed [31:0] acc_reg;
   logic signed [31:0] acc_next;
   logic [MW-1:0]      hold_reg;
   logic [MW-1:0]      min_ticks;
   logic               sw_on_reg;
   logic               sw_req;
   logic               fixed_mode;
   logic               valve;
   logic               inv_b;
   ltp_pkg::ltp_sby_e  sby_b;
   ltp_pkg::ltp_func_e b_fn;
   logic               raise_req;
   logic               lower_req;
   logic               tp_level;
   logic               a_lvl;
   logic               b_lvl;
   logic               out_a_next;
   logic               out_b_next;
   logic               out_a_reg;
   logic               out_b_reg;
   ltp_pkg::ltp_func_e b_func_reg;
   logic               algo_reg;

   // True where the inversion setting may act on a channel function.
   function automatic logic inv_ok(ltp_pkg::ltp_func_e fn);
      return fn != ltp_pkg::LTP_FN_TPROP && fn != ltp_pkg::LTP_FN_RAISE;
   endfunction : inv_ok

   // Applies the standby action to a level that is already inverted.
   function automatic logic sby_f(logic lvl, logic sb,
                                  ltp_pkg::ltp_sby_e act);
      if (!sb) begin
         return lvl;
      end
      case (act)
         ltp_pkg::LTP_SBY_OFF: return 1'b0;
         ltp_pkg::LTP_SBY_ON:  return 1'b1;
         default:              return lvl;
      endcase
   endfunction : sby_f

   // On ticks of one fixed period for a given duty.
   function automatic logic [PW-1:0] on_ticks_f(logic [13:0] d,
                                                logic [PW-1:0] p);
      logic [PW+13:0] prod;
      prod = ((PW+14)'(d) * (PW+14)'(p)) / (PW+14)'(ltp_pkg::FULL_SCALE);
      return prod[PW-1:0];
   endfunction : on_ticks_f

   // Scaler gets the held demand and the four limits.
   assign sc.demand = dem_reg;
   assign sc.dmd_lo = DEMAND_LO;
   assign sc.dmd_hi = DEMAND_HI;
   assign sc.out_lo = OUTPUT_LO;
   assign sc.out_hi = OUTPUT_HI;

   ltp_scaler u_scaler (
      .clk (CLK),
      .rst (RST),
      .sc  (sc.scl)
   );

   // Tick prescaler, one tick every TICK_CYC clocks.
   assign tick = pre_reg == TW'(TICK_CYC - 1);

   always_ff @(posedge CLK) begin
      if (RST || tick) begin
         pre_reg <= '0;
      end else begin
         pre_reg <= pre_reg + TW'(1);
      end
   end

   // First channel demand follows wire, comms writes or holds.
   always_ff @(posedge CLK) begin
      if (RST) begin
         dem_reg <= ltp_pkg::DEMAND_RST;
      end else if (SRC_A == ltp_pkg::LTP_SRC_WIRE) begin
         dem_reg <= DEMAND_WIRE;
      end else if (SRC_A == ltp_pkg::LTP_SRC_COMMS && COMMS_WE_A) begin
         dem_reg <= COMMS_DEMAND_A;
      end else begin
         dem_reg <= dem_reg;
      end
   end

   // Second channel level follows wire, comms writes or holds.
   always_ff @(posedge CLK) begin
      if (RST) begin
         lvl_b_reg <= 1'b0;
      end else if (SRC_B == ltp_pkg::LTP_SRC_WIRE) begin
         lvl_b_reg <= LEVEL_B_WIRE;
      end else if (SRC_B == ltp_pkg::LTP_SRC_COMMS && COMMS_WE_B) begin
         lvl_b_reg <= COMMS_LEVEL_B;
      end else begin
         lvl_b_reg <= lvl_b_reg;
      end
   end

   // A zero period selects the minimum switch time algorithm.
   assign fixed_mode = FIXED_PERIOD != '0;

   // Zero minimum time means the automatic value.
   assign min_ticks = (MIN_SWITCH == '0) ?
                      MW'(ltp_pkg::AUTO_MIN_TICKS) : MIN_SWITCH;

   // Fixed period phase; on time is latched at each period start.
   always_ff @(posedge CLK) begin
      if (RST) begin
         ph_reg       <= '0;
         on_ticks_reg <= '0;
      end else if (!fixed_mode) begin
         ph_reg       <= '0;
         on_ticks_reg <= on_ticks_f(sc.duty, FIXED_PERIOD);
      end else if (tick) begin
         if (ph_reg >= FIXED_PERIOD - PW'(1)) begin
            ph_reg       <= '0;
            on_ticks_reg <= on_ticks_f(sc.duty, FIXED_PERIOD);
         end else begin
            ph_reg <= ph_reg + PW'(1);
         end
      end
   end

   // Error accumulator of duty against the present output state.
   always_comb begin
      acc_next = acc_reg + 32'(sc.duty)
                 - (sw_on_reg ? 32'(ltp_pkg::FULL_SCALE) : 32'h00000000);
      sw_req = hold_reg >= min_ticks &&
               (sw_on_reg ? (acc_next < 32'sh00000000)
                          : (acc_next > 32'sh00000000));
   end

   // Minimum switch time engine, idle while the fixed period runs.
   always_ff @(posedge CLK) begin
      if (RST || fixed_mode) begin
         acc_reg   <= 32'sh00000000;
         hold_reg  <= '0;
         sw_on_reg <= 1'b0;
      end else if (tick) begin
         acc_reg <= acc_next;
         if (sw_req) begin
            sw_on_reg <= !sw_on_reg;
            hold_reg  <= MW'(1);
         end else if (hold_reg != '1) begin
            hold_reg <= hold_reg + MW'(1);
         end
      end
   end

   // Effective second channel setup and raw channel levels.
   always_comb begin
      valve     = FUNC_A == ltp_pkg::LTP_FN_RAISE;
      b_fn      = valve ? ltp_pkg::LTP_FN_LOWER : FUNC_B;
      inv_b     = valve ? INVERT_A : INVERT_B;
      sby_b     = valve ? SBY_A : SBY_B;
      raise_req = dem_reg != 14'h0000;
      lower_req = lvl_b_reg;
      tp_level  = fixed_mode ? (ph_reg < on_ticks_reg) : sw_on_reg;
      case (FUNC_A)
         ltp_pkg::LTP_FN_TPROP: a_lvl = tp_level;
         ltp_pkg::LTP_FN_RAISE: a_lvl = raise_req && !lower_req;
         default:               a_lvl = raise_req;
      endcase
      a_lvl = a_lvl ^ (INVERT_A && inv_ok(FUNC_A));
      if (valve) begin
         b_lvl = (lower_req && !raise_req) ^ inv_b;
      end else begin
         b_lvl = lvl_b_reg ^ (inv_b && inv_ok(b_fn));
      end
   end

   // Calibration, standby and continue handling ahead of the pins.
   always_comb begin
      out_a_next = sby_f(a_lvl, STANDBY, SBY_A);
      out_b_next = sby_f(b_lvl, STANDBY, sby_b);
      if (valve) begin
         if (CAL_STATE == ltp_pkg::LTP_CAL_RAISE) begin
            out_a_next = 1'b1;
            out_b_next = 1'b0;
         end else if (CAL_STATE == ltp_pkg::LTP_CAL_LOWER) begin
            out_a_next = 1'b0;
            out_b_next = 1'b1;
         end else if (STANDBY && (SBY_A == ltp_pkg::LTP_SBY_FREEZE ||
                                  SBY_A == ltp_pkg::LTP_SBY_OFF)) begin
            out_a_next = 1'b0;
            out_b_next = 1'b0;
         end else begin
            out_a_next = a_lvl;
            out_b_next = b_lvl;
         end
      end
   end

   // Output pin registers.
   always_ff @(posedge CLK) begin
      if (RST) begin
         out_a_reg <= 1'b0;
         out_b_reg <= 1'b0;
      end else begin
         out_a_reg <= out_a_next;
         out_b_reg <= out_b_next;
      end
   end

   // Status registers: effective second function and active algorithm.
   always_ff @(posedge CLK) begin
      if (RST) begin
         b_func_reg <= ltp_pkg::LTP_FN_ONOFF;
         algo_reg   <= 1'b0;
      end else begin
         b_func_reg <= b_fn;
         algo_reg   <= fixed_mode;
      end
   end

   assign OUT_A      = out_a_reg;
   assign OUT_B      = out_b_reg;
   assign B_FUNC     = b_func_reg;
   assign ALGO_FIXED = algo_reg;
   assign DUTY       = sc.duty;

   default clocking @(posedge CLK); endclocking
   default disable iff (RST);

   sequence plain_sby_s(ltp_pkg::ltp_sby_e act);
      !valve && STANDBY && SBY_A == act;
   endsequence

   sequence freeze_s;
      valve && STANDBY && CAL_STATE == ltp_pkg::LTP_CAL_IDLE &&
      SBY_A == ltp_pkg::LTP_SBY_FREEZE;
   endsequence

   sequence cal_s(ltp_pkg::ltp_cal_e st);
      valve && CAL_STATE == st;
   endsequence

   b_forced_a: assert property (
      valve |=> B_FUNC == ltp_pkg::LTP_FN_LOWER)
      else $error("Second channel not forced to valve lower.");

   cfg_copy_a: assert property (
      valve |-> inv_b == INVERT_A && sby_b == SBY_A)
      else $error("Valve mode settings not copied to second channel.");

   sby_low_a: assert property (
      plain_sby_s(ltp_pkg::LTP_SBY_OFF) |=> !OUT_A)
      else $error("Standby off did not drive output low.");

   sby_high_a: assert property (
      plain_sby_s(ltp_pkg::LTP_SBY_ON) |=> OUT_A)
      else $error("Standby on did not drive output high.");

   valve_freeze_a: assert property (
      freeze_s |=> !OUT_A && !OUT_B)
      else $error("Valve outputs still driving in freeze.");

   cal_raise_a: assert property (
      cal_s(ltp_pkg::LTP_CAL_RAISE) |=> OUT_A && !OUT_B)
      else $error("Calibration raise not driving open.");

   cal_lower_a: assert property (
      cal_s(ltp_pkg::LTP_CAL_LOWER) |=> !OUT_A && OUT_B)
      else $error("Calibration lower not driving closed.");

   min_hold_a: assert property (
      (!fixed_mode && $past(!fixed_mode) && sw_on_reg != $past(sw_on_reg))
      |-> $past(hold_reg) >= $past(min_ticks))
      else $error("Output switched before minimum time.");

   fixed_off_a: assert property (
      (fixed_mode && FUNC_A == ltp_pkg::LTP_FN_TPROP && !STANDBY &&
       ph_reg >= on_ticks_reg) |=> !OUT_A)
      else $error("Fixed period output on past its on time.");

   one_algo_a: assert property (
      fixed_mode |=> !sw_on_reg && acc_reg == 32'sh00000000)
      else $error("Both algorithms active together.");

   auto_min_a: assert property (
      MIN_SWITCH == '0 |-> min_ticks == MW'(ltp_pkg::AUTO_MIN_TICKS))
      else $error("Automatic minimum time not applied.");

endmodule : ltp_top

// [pkg/ltp_pkg.sv]
// Shared constants and types of the logic output time proportioning block.
// Assumes a single 100 MHz system clock and demand values in 0.01 % steps.
package ltp_pkg;

   // Clock period and the base tick of all output timing.
   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_MS       = 10;
   localparam int TICK_CYC      = TICK_MS * 1000000 / CLK_PERIOD_NS;

   // Automatic minimum switch time, the fastest output update.
   localparam int          AUTO_MIN_MS    = 20;
   localparam logic [13:0] AUTO_MIN_TICKS = 14'(AUTO_MIN_MS / TICK_MS);

   // Widths of demand, period and minimum time values.
   localparam int DEMAND_W = 14;
   localparam int PERIOD_W = 12;
   localparam int MIN_W    = 14;

   // Full scale demand, 100.00 % in 0.01 % steps.
   localparam logic [13:0] FULL_SCALE = 14'h2710;

   // Values after reset.
   localparam logic [13:0] DUTY_RST   = 14'h0000;
   localparam logic [13:0] DEMAND_RST = 14'h0000;

   // Function of a logic channel.
   typedef enum logic [1:0] {
      LTP_FN_ONOFF = 2'b00,
      LTP_FN_TPROP = 2'b01,
      LTP_FN_RAISE = 2'b10,
      LTP_FN_LOWER = 2'b11
   } ltp_func_e;

   // Action of a channel while the controller is in standby.
   typedef enum logic [1:0] {
      LTP_SBY_OFF    = 2'b00,
      LTP_SBY_ON     = 2'b01,
      LTP_SBY_CONT   = 2'b10,
      LTP_SBY_FREEZE = 2'b11
   } ltp_sby_e;

   // Where the value driving a channel comes from.
   typedef enum logic [1:0] {
      LTP_SRC_WIRE  = 2'b00,
      LTP_SRC_COMMS = 2'b01,
      LTP_SRC_NONE  = 2'b10
   } ltp_src_e;

   // Manual valve calibration drive.
   typedef enum logic [1:0] {
      LTP_CAL_IDLE  = 2'b00,
      LTP_CAL_RAISE = 2'b01,
      LTP_CAL_LOWER = 2'b10
   } ltp_cal_e;

endpackage : ltp_pkg

// [pkg/ltp_scale_if.sv]
// Interface between the output controller and the demand scaler.
// Assumes both ends run on the same clock.
interface ltp_scale_if;
   logic [13:0] demand;
   logic [13:0] dmd_lo;
   logic [13:0] dmd_hi;
   logic [13:0] out_lo;
   logic [13:0] out_hi;
   logic [13:0] duty;

   // Controller side supplies demand and limits, scaler returns duty.
   modport ctl (output demand, dmd_lo, dmd_hi, out_lo, out_hi,
                input  duty);
   modport scl (input  demand, dmd_lo, dmd_hi, out_lo, out_hi,
                output duty);
endinterface : ltp_scale_if

// [src/ltp_scaler.sv]
// Demand to duty scaler with a registered result.
// Assumes limits in 0.01 % steps and a synchronous active high reset.
module ltp_scaler (
   input wire logic clk,
   input wire logic rst,
   ltp_scale_if.scl sc
);

   logic [13:0] duty_reg;

   // Maps demand linearly between the output limits, clamped at the ends.
   function automatic logic [13:0] scale_f(
      logic [13:0] d, logic [13:0] dl, logic [13:0] dh,
      logic [13:0] ol, logic [13:0] oh);
      logic [27:0] q;
      q = 28'h0000000;
      if (d <= dl) begin
         return ol;
      end
      if (d >= dh) begin
         return oh;
      end
      if (oh >= ol) begin
         q = (28'(d - dl) * 28'(oh - ol)) / 28'(dh - dl);
         return ol + q[13:0];
      end
      q = (28'(d - dl) * 28'(ol - oh)) / 28'(dh - dl);
      return ol - q[13:0];
   endfunction : scale_f

   // Duty register, refreshed every clock.
   always_ff @(posedge clk) begin
      if (rst) begin
         duty_reg <= ltp_pkg::DUTY_RST;
      end else begin
         duty_reg <= scale_f(sc.demand, sc.dmd_lo, sc.dmd_hi,
                             sc.out_lo, sc.out_hi);
      end
   end

   assign sc.duty = duty_reg;

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   sequence at_low_s;
      sc.demand <= sc.dmd_lo;
   endsequence

   sequence at_high_s;
      sc.demand >= sc.dmd_hi && sc.demand > sc.dmd_lo;
   endsequence

   low_limit_a: assert property (
      at_low_s |=> sc.duty == $past(sc.out_lo))
      else $error("Duty differs from lower output limit.");

   high_limit_a: assert property (
      at_high_s |=> sc.duty == $past(sc.out_hi))
      else $error("Duty differs from upper output limit.");

   duty_range_a: assert property (
      ##1 ((sc.duty >= $past(sc.out_lo) || sc.duty >= $past(sc.out_hi))
      && (sc.duty <= $past(sc.out_lo) || sc.duty <= $past(sc.out_hi))))
      else $error("Duty lies outside the output limits.");

endmodule : ltp_scaler

// [dv/ltp_relay_model.sv]
// Model of the switching device wired to the first channel's pin.
// Assumes the pin is sampled on the rising edge of the system clock.
module ltp_relay_model (
   input  wire logic clk,
   input  wire logic clr,
   input  wire logic drive,
   output logic      energised,
   output int        on_cycles,
   output int        min_run,
   output int        switches
);
   timeunit 1ns;
   timeprecision 1ns;

   int run;

   // The coil follows the pin; on time and the shortest whole run are kept.
   always @(posedge clk) begin
      if (clr) begin
         on_cycles <= 0;
         min_run   <= 1000000;
         switches  <= 0;
         run       <= 0;
      end else begin
         if (drive)
            on_cycles <= on_cycles + 1;
         if (drive !== energised) begin
            if (switches > 0 && run < min_run)
               min_run <= run;
            switches <= switches + 1;
            run      <= 1;
         end else begin
            run <= run + 1;
         end
      end
      energised <= clr ? 1'b0 : drive;
   end
endmodule : ltp_relay_model

// [dv/testbench.sv]
// Self-checking bench of the logic output pair with a relay on channel A.
// Assumes the design's package is compiled first and a short tick of 4.
module testbench;
   timeunit 1ns;
   timeprecision 1ns;

   localparam int TK = 4;

   logic               clk = 1'b0;
   logic               rst, standby, inv_a, inv_b, lvl_wire, clr;
   logic               we_a, we_b, lvl_comms, out_a, out_b, algo;
   ltp_pkg::ltp_func_e func_a, func_b, b_func;
   ltp_pkg::ltp_sby_e  sby_a, sby_b;
   ltp_pkg::ltp_src_e  src_a, src_b;
   ltp_pkg::ltp_cal_e  cal;
   logic [11:0]        period;
   logic [13:0]        min_sw, dlo, dhi, olo, ohi, dwire, dcomms, duty;
   logic [13:0]        d, a, b;
   logic [31:0]        rng_state = 32'd90611;
   int                 on_cyc, min_run, nsw, failures, tests_run, exp_on;
   int                 pt[5] = '{20, 20, 20, 25, 25};
   int                 pd[5] = '{0, 5000, 10000, 0, 10000};

   // The clock runs at 100 MHz.
   always #5 clk = ~clk;

   ltp_top #(.TICK_CYC(TK)) DUT (
      .CLK(clk), .RST(rst), .STANDBY(standby), .FUNC_A(func_a),
      .FUNC_B(func_b), .INVERT_A(inv_a), .INVERT_B(inv_b),
      .SBY_A(sby_a), .SBY_B(sby_b), .SRC_A(src_a), .SRC_B(src_b),
      .CAL_STATE(cal), .FIXED_PERIOD(period), .MIN_SWITCH(min_sw),
      .DEMAND_LO(dlo), .DEMAND_HI(dhi), .OUTPUT_LO(olo), .OUTPUT_HI(ohi),
      .DEMAND_WIRE(dwire), .LEVEL_B_WIRE(lvl_wire), .COMMS_WE_A(we_a),
      .COMMS_DEMAND_A(dcomms), .COMMS_WE_B(we_b),
      .COMMS_LEVEL_B(lvl_comms), .OUT_A(out_a), .OUT_B(out_b),
      .B_FUNC(b_func), .ALGO_FIXED(algo), .DUTY(duty)
   );

   ltp_relay_model RELAY (
      .clk(clk), .clr(clr), .drive(out_a), .energised(),
      .on_cycles(on_cyc), .min_run(min_run), .switches(nsw)
   );

   // Xorshift generator for repeatable random stimulus.
   function automatic logic [31:0] rnd();
      rng_state = rng_state ^ (rng_state << 13);
      rng_state = rng_state ^ (rng_state >> 17);
      rng_state = rng_state ^ (rng_state << 5);
      return rng_state;
   endfunction : rnd

   // Expected duty: clamped linear map between the output limits.
   function automatic logic [13:0] exp_duty(input logic [13:0] dm);
      if (dm <= dlo)
         return olo;
      if (dm >= dhi)
         return ohi;
      return 14'(int'(dm - dlo) * int'(ohi - olo) / int'(dhi - dlo) + int'(olo));
   endfunction : exp_duty

   // Waits a number of edges and lets their updates settle.
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step

   // Compares one value and counts the outcome.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: got %0h expected %0h",
                  $time, got, exp);
      end
   endtask : chk

   // Sets channel A demand by wire or by a one-cycle comms write.
   task automatic put_a(input logic [13:0] dm, input logic comms);
      src_a = comms ? ltp_pkg::LTP_SRC_COMMS : ltp_pkg::LTP_SRC_WIRE;
      if (comms) begin
         dwire  = ~dm;
         dcomms = dm;
         we_a   = 1'b1;
         step(1);
         we_a = 1'b0;
      end else begin
         dwire = dm;
      end
      step(3);
   endtask : put_a

   // Restarts the relay's counters, then lets n cycles pass.
   task automatic watch(input int n);
      clr = 1'b1;
      step(1);
      clr = 1'b0;
      step(n);
   endtask : watch

   // Prints the counts and the verdict, then stops.
   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : end_of_test

   // A hung run is cut short and counted as a mismatch.
   initial begin
      #400000;
      failures++;
      end_of_test();
   end

   // Main sequence.
   initial begin
      rst = 1'b1; standby = 1'b0; inv_a = 1'b0; inv_b = 1'b0; clr = 1'b1;
      lvl_wire = 1'b0; we_a = 1'b0; we_b = 1'b0; lvl_comms = 1'b0;
      func_a = ltp_pkg::LTP_FN_ONOFF; func_b = ltp_pkg::LTP_FN_ONOFF;
      sby_a = ltp_pkg::LTP_SBY_OFF; sby_b = ltp_pkg::LTP_SBY_OFF;
      src_a = ltp_pkg::LTP_SRC_WIRE; src_b = ltp_pkg::LTP_SRC_WIRE;
      cal = ltp_pkg::LTP_CAL_IDLE; period = 12'h000; min_sw = 14'h0000;
      dlo = 14'h0000; dhi = 14'h2710; olo = 14'h0000; ohi = 14'h2710;
      dwire = 14'h0000; dcomms = 14'h0000;
      step(3);
      rst = 1'b0;
      clr = 1'b0;
      chk({out_a, out_b, b_func, algo, duty}, 32'h0);
      // Random limits and demands, continuing in standby from both sources.
      standby = 1'b1;
      sby_a   = ltp_pkg::LTP_SBY_CONT;
      for (int i = 0; i < 40; i++) begin
         dlo = 14'(rnd() % 5000);
         dhi = 14'(dlo + 1 + rnd() % 5000);
         a   = 14'(rnd() % 10001);
         b   = 14'(rnd() % 10001);
         olo = (a < b) ? a : b;
         ohi = (a < b) ? b : a;
         inv_a = 1'(rnd());
         d = (i % 4 == 0) ? dlo : (i % 4 == 1) ? dhi : 14'(rnd() % 10001);
         put_a(d, i[0]);
         chk(duty, exp_duty(d));
         chk(out_a, (d != 0) ^ inv_a);
      end
      // Forced standby levels regardless of inversion.
      dlo = 14'h0000; dhi = 14'h2710; olo = 14'h0000; ohi = 14'h2710;
      for (int k = 0; k < 4; k++) begin
         inv_a = k[0];
         sby_a = k[1] ? ltp_pkg::LTP_SBY_ON : ltp_pkg::LTP_SBY_OFF;
         put_a(14'(k * 100), 1'b0);
         if (k[1])
            chk(out_a, 1);
         else
            chk(out_a, 0);
      end
      // Channel B continuing in standby: wire, comms, then hold.
      sby_b = ltp_pkg::LTP_SBY_CONT;
      lvl_wire = 1'b1;
      step(3);
      chk(out_b, 1);
      lvl_wire = 1'b0;
      step(3);
      chk(out_b, 0);
      src_b = ltp_pkg::LTP_SRC_COMMS;
      lvl_wire = 1'b0;
      lvl_comms = 1'b1;
      we_b = 1'b1;
      step(1);
      we_b = 1'b0;
      step(3);
      chk(out_b, 1);
      src_b = ltp_pkg::LTP_SRC_NONE;
      lvl_wire = 1'b0;
      step(3);
      chk(out_b, 1);
      // Valve pair: forced lower channel, shared settings, calibration.
      standby = 1'b0; func_a = ltp_pkg::LTP_FN_RAISE; inv_a = 1'b0;
      inv_b = 1'b1; sby_b = ltp_pkg::LTP_SBY_ON; sby_a = ltp_pkg::LTP_SBY_OFF;
      src_b = ltp_pkg::LTP_SRC_WIRE; lvl_wire = 1'b1;
      put_a(14'h0000, 1'b0);
      chk(b_func, ltp_pkg::LTP_FN_LOWER);
      chk({out_a, out_b}, 2'b01);
      lvl_wire = 1'b0;
      inv_a = 1'b1;
      put_a(14'h01F4, 1'b0);
      chk({out_a, out_b}, 2'b11);
      inv_a = 1'b0;
      put_a(14'h0000, 1'b0);
      cal = ltp_pkg::LTP_CAL_RAISE;
      step(2);
      chk({out_a, out_b}, 2'b10);
      cal = ltp_pkg::LTP_CAL_LOWER;
      step(2);
      chk({out_a, out_b}, 2'b01);
      cal = ltp_pkg::LTP_CAL_IDLE; lvl_wire = 1'b1; standby = 1'b1;
      sby_a = ltp_pkg::LTP_SBY_FREEZE;
      step(3);
      chk({out_a, out_b}, 2'b00);
      sby_a = ltp_pkg::LTP_SBY_CONT;
      step(3);
      chk(out_b, 1);
      lvl_wire = 1'b0;
      step(3);
      chk(out_b, 0);
      // Fixed period on time, inversion set, default and offset limits.
      standby = 1'b0; func_a = ltp_pkg::LTP_FN_TPROP; inv_a = 1'b1;
      for (int i = 0; i < 5; i++) begin
         olo = (i > 2) ? 14'h0320 : 14'h0000;
         ohi = (i > 2) ? 14'h2328 : 14'h2710;
         period = 12'(pt[i]);
         put_a(14'(pd[i]), 1'b0);
         chk(algo, 1);
         step(pt[i] * TK * 2);
         watch(pt[i] * TK * 2);
         exp_on = int'(exp_duty(14'(pd[i]))) * pt[i] / 10000 * TK * 2;
         chk(on_cyc, exp_on);
      end
      // Minimum switch time, automatic and then five ticks.
      period = 12'h000;
      put_a(14'h1388, 1'b0);
      chk(algo, 0);
      watch(400);
      chk(min_run, 2 * TK);
      chk(nsw > 4, 1);
      min_sw = 14'h0005;
      watch(600);
      chk(min_run, 5 * TK);
      end_of_test();
   end
endmodule : testbench
